//--- srpcd_pkg.sv
// Constants, timing counts and state types of the redriver control block.
// Assumes a single 10 MHz control clock; all pin inputs are synchronous to it.
package srpcd_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  // Longest time from enable falling to standby
  localparam int DIS_TIME_NS = 2000;
  localparam int DIS_CYC = (DIS_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : DIS_TIME_NS / CLK_PERIOD_NS;
  // Longest time from enable rising to normal operation
  localparam int RESUME_TIME_NS = 20000;
  localparam int RESUME_CYC =
    (RESUME_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : RESUME_TIME_NS / CLK_PERIOD_NS;
  // Idle must last more than this before a channel drops to low power
  localparam int IDLE_TIME_NS = 18000;
  localparam int IDLE_CYC = (IDLE_TIME_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;
  // Longest low power exit and squelch switching times
  localparam int ALP_EXIT_TIME_NS = 50;
  localparam int ALP_EXIT_CYC =
    (ALP_EXIT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : ALP_EXIT_TIME_NS / CLK_PERIOD_NS;
  localparam int SQUELCH_TIME_NS = 5;
  localparam int SQUELCH_CYC =
    (SQUELCH_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : SQUELCH_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  // Control fields
  localparam int CTRL_SW_ENABLE_BIT = 0;
  localparam int CTRL_ALP_ALLOW_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // Status fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_STANDBY_BIT = 1;
  localparam int STAT_LP_CH1_BIT = 2;
  localparam int STAT_LP_CH2_BIT = 3;
  localparam int STAT_CABLE_N_BIT = 4;
  localparam int STAT_LISTEN_BIT = 5;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // State types
  typedef enum logic [1:0] {PWR_STANDBY, PWR_WAKE, PWR_ACTIVE} srpcd_power_type;
  typedef enum logic {DET_SENSE, DET_LISTEN} srpcd_detect_type;

endpackage

//--- srpcd_idle_timer.sv
// Per-channel squelch, data pass and auto low power control.
// Assumes rxActivity is the synchronous output of the channel's signal detector.
`timescale 1ns/1ns
module srpcd_idle_timer #(
  parameter int IDLE_CYC = srpcd_pkg::IDLE_CYC,
  parameter int CNT_W = 8
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Control
  input wire logic run,
  input wire logic alpAllow,
  input wire logic rxActivity,
  // Channel state
  output logic lowPower_q,
  output logic squelch_q,
  output logic pass_q
);

  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYC - 1);

  logic [CNT_W-1:0] idleCnt_q;

  // ==========================================================================
  // Idle counter, saturating one short of the entry count
  always_ff @(posedge ref_clk) begin
    if (srst || (clkEn && !run)) begin
      idleCnt_q <= '0;
    end else if (clkEn) begin
      if (rxActivity) begin
        idleCnt_q <= '0;
      end else if (idleCnt_q != IDLE_LAST) begin
        idleCnt_q <= idleCnt_q + CNT_W'(1);
      end
    end
  end

  // ==========================================================================
  // Low power state; activity wins over entry in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst || (clkEn && !run)) begin
      lowPower_q <= 1'b0;
    end else if (clkEn) begin
      if (rxActivity) begin
        lowPower_q <= 1'b0;
      end else if (alpAllow && idleCnt_q == IDLE_LAST) begin
        lowPower_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Squelch follows the detector within one cycle
  always_ff @(posedge ref_clk) begin
    if (srst || (clkEn && !run)) begin
      squelch_q <= 1'b1;
      pass_q <= 1'b0;
    end else if (clkEn) begin
      squelch_q <= !rxActivity;
      pass_q <= rxActivity;
    end
  end

  // ==========================================================================
  // Checks
  idle_entry_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && run && alpAllow && !rxActivity && idleCnt_q == IDLE_LAST |=> lowPower_q)
    else $error("channel did not enter low power after idle time");

  idle_early_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(lowPower_q) |-> $past(idleCnt_q) == IDLE_LAST)
    else $error("channel entered low power before idle time");

  alp_exit_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && run && rxActivity |=> !lowPower_q && !squelch_q)
    else $error("channel did not leave low power on activity");

  squelch_pass_a: assert property (@(posedge ref_clk) disable iff (srst)
    pass_q |-> !squelch_q && !lowPower_q)
    else $error("channel passes data while squelched");

endmodule // srpcd_idle_timer

//--- srpcd_top.sv
// Control logic of a two-channel SATA redriver: standby sequencing,
// per-channel auto low power and squelch, pre-emphasis select, cable detect,
// and an AXI4-Lite register slave.
// Assumes all pins are synchronous to ref_clk and that detector outputs are
// already digital; channel 1 faces the host, channel 2 the external socket.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module srpcd_top #(
  parameter int RESUME_CYC = srpcd_pkg::RESUME_CYC,
  parameter int IDLE_CYC = srpcd_pkg::IDLE_CYC,
  parameter int ADDR_W = 4
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Control pins
  input wire logic enable,
  input wire logic cable_detect_select,
  input wire logic preemph_sel_ch1,
  input wire logic preemph_sel_ch2,
  // Detector inputs, index 0 is channel 1
  input wire logic [1:0] rxActivity,
  input wire logic hostOob,
  input wire logic ch1TermSensed,
  input wire logic ch2Cominit,
  // Output stage control, index 0 is channel 1
  output logic [1:0] txDriveEn,
  output logic [1:0] auto_low_power,
  output logic [1:0] txCommonMode,
  output logic [1:0] txPass,
  output logic [1:0] txPreemph,
  output logic biasOn,
  // Status pin
  output logic cable_present_n,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int WAKE_W = $clog2(RESUME_CYC + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(RESUME_CYC - 1);

  srpcd_pkg::srpcd_power_type powerState_q;
  srpcd_pkg::srpcd_power_type powerState_d;
  srpcd_pkg::srpcd_detect_type detState_q;
  logic [WAKE_W-1:0] wakeCnt_q;
  logic [1:0] ctrl_q;
  logic enEff;
  logic running;
  logic runGate;
  logic cdActive;
  logic [1:0] lowPower;
  logic [1:0] squelch;
  logic [1:0] pass;

  assign enEff = enable && ctrl_q[srpcd_pkg::CTRL_SW_ENABLE_BIT];
  assign running = powerState_q == srpcd_pkg::PWR_ACTIVE;
  // Enable is looked at directly so timers and detect clear on the same edge
  // that enters standby, not one cycle after it
  assign runGate = running && enEff;
  assign cdActive = cable_detect_select && runGate;

  // ==========================================================================
  // Power sequencing: standby is entered at once, wake takes a fixed delay
  always_comb begin
    powerState_d = powerState_q;
    case (powerState_q)
      srpcd_pkg::PWR_STANDBY: if (enEff) powerState_d = srpcd_pkg::PWR_WAKE;
      srpcd_pkg::PWR_WAKE: begin
        if (!enEff) begin
          powerState_d = srpcd_pkg::PWR_STANDBY;
        end else if (wakeCnt_q == WAKE_LAST) begin
          powerState_d = srpcd_pkg::PWR_ACTIVE;
        end
      end
      srpcd_pkg::PWR_ACTIVE: if (!enEff) powerState_d = srpcd_pkg::PWR_STANDBY;
      default: powerState_d = srpcd_pkg::PWR_STANDBY;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      powerState_q <= srpcd_pkg::PWR_STANDBY;
      wakeCnt_q <= '0;
    end else if (clkEn) begin
      powerState_q <= powerState_d;
      if (powerState_d == srpcd_pkg::PWR_WAKE) begin
        wakeCnt_q <= wakeCnt_q + WAKE_W'(1);
      end else begin
        wakeCnt_q <= '0;
      end
    end
  end

  // Output drivers and bias follow the next state so they switch with it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txDriveEn <= 2'h0;
      biasOn <= 1'b0;
    end else if (clkEn) begin
      txDriveEn <= {2{powerState_d != srpcd_pkg::PWR_STANDBY}};
      biasOn <= powerState_d != srpcd_pkg::PWR_STANDBY;
    end
  end

  // ==========================================================================
  // Per-channel idle, squelch and low power; held in reset outside active
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    srpcd_idle_timer #(
      .IDLE_CYC(IDLE_CYC),
      .CNT_W($clog2(IDLE_CYC + 1))
    ) u_timer (
      .ref_clk(ref_clk),
      .srst(srst),
      .clkEn(clkEn),
      .run(runGate),
      .alpAllow(ctrl_q[srpcd_pkg::CTRL_ALP_ALLOW_BIT]),
      .rxActivity(rxActivity[ch]),
      .lowPower_q(lowPower[ch]),
      .squelch_q(squelch[ch]),
      .pass_q(pass[ch])
    );
  end

  assign auto_low_power = lowPower;
  assign txPass = pass;
  assign txCommonMode = squelch;

  // ==========================================================================
  // Pre-emphasis select, one pin per channel
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txPreemph <= 2'h0;
    end else if (clkEn) begin
      txPreemph <= {preemph_sel_ch2, preemph_sel_ch1};
    end
  end

  // ==========================================================================
  // Cable detect. A sleeping host sends no OOB, so a removal is only seen at
  // the next wake burst, which keeps the status low in the meantime.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      detState_q <= srpcd_pkg::DET_SENSE;
      cable_present_n <= 1'b0;
    end else if (clkEn) begin
      if (!cdActive) begin
        detState_q <= srpcd_pkg::DET_SENSE;
        cable_present_n <= 1'b0;
      end else begin
        case (detState_q)
          srpcd_pkg::DET_SENSE: begin
            if (hostOob && !ch1TermSensed) begin
              detState_q <= srpcd_pkg::DET_LISTEN;
              cable_present_n <= 1'b1;
            end
          end
          srpcd_pkg::DET_LISTEN: begin
            if (ch2Cominit) begin
              detState_q <= srpcd_pkg::DET_SENSE;
              cable_present_n <= 1'b0;
            end
          end
          default: begin
            detState_q <= srpcd_pkg::DET_SENSE;
            cable_present_n <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write: address and data taken in either order, one at a time
  logic awHeld_q;
  logic wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;

  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Ready is a register: low while a held item waits for its partner
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clkEn) begin
      s_axi_awready <= !(awHeld_q || (s_axi_awvalid && s_axi_awready)) || doWrite;
      s_axi_wready <= !(wHeld_q || (s_axi_wvalid && s_axi_wready)) || doWrite;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srpcd_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q == srpcd_pkg::CTRL_ADDR[ADDR_W-1:0] ||
                        awAddr_q == srpcd_pkg::STATUS_ADDR[ADDR_W-1:0]) ?
                       srpcd_pkg::RESP_OKAY : srpcd_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; status is read-only and ignores writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= srpcd_pkg::CTRL_RESET;
    end else if (clkEn && doWrite && wStrb_q[0] &&
                 awAddr_q == srpcd_pkg::CTRL_ADDR[ADDR_W-1:0]) begin
      ctrl_q <= wData_q[1:0];
    end
  end

  // ==========================================================================
  // AXI4-Lite read: one cycle from address to data
  logic [31:0] statusWord;

  always_comb begin
    statusWord = 32'h0;
    statusWord[srpcd_pkg::STAT_ACTIVE_BIT] = running;
    statusWord[srpcd_pkg::STAT_STANDBY_BIT] = powerState_q == srpcd_pkg::PWR_STANDBY;
    statusWord[srpcd_pkg::STAT_LP_CH1_BIT] = lowPower[0];
    statusWord[srpcd_pkg::STAT_LP_CH2_BIT] = lowPower[1];
    statusWord[srpcd_pkg::STAT_CABLE_N_BIT] = cable_present_n;
    statusWord[srpcd_pkg::STAT_LISTEN_BIT] = detState_q == srpcd_pkg::DET_LISTEN;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= srpcd_pkg::RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= srpcd_pkg::RESP_OKAY;
        if (s_axi_araddr == srpcd_pkg::CTRL_ADDR[ADDR_W-1:0]) begin
          s_axi_rdata <= {30'h0, ctrl_q};
        end else if (s_axi_araddr == srpcd_pkg::STATUS_ADDR[ADDR_W-1:0]) begin
          s_axi_rdata <= statusWord;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= srpcd_pkg::RESP_DECERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  standby_entry_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && !enEff |=> powerState_q == srpcd_pkg::PWR_STANDBY && !biasOn)
    else $error("standby not entered after enable fell");

  standby_hiz_a: assert property (@(posedge ref_clk) disable iff (srst)
    powerState_q == srpcd_pkg::PWR_STANDBY |-> txDriveEn == 2'h0)
    else $error("outputs driven in standby");

  resume_bound_a: assert property (@(posedge ref_clk) disable iff (srst)
    powerState_q == srpcd_pkg::PWR_WAKE |-> wakeCnt_q <= WAKE_LAST && wakeCnt_q != '0)
    else $error("wake delay outside its bound");

  standby_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
    !running |-> auto_low_power == 2'h0 && txPass == 2'h0 && !cable_present_n)
    else $error("low power or detect active outside normal operation");

  cd_powerup_a: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(srst) |-> !cable_present_n)
    else $error("status not low after reset");

  cd_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && !cdActive |=> !cable_present_n && detState_q == srpcd_pkg::DET_SENSE)
    else $error("cable detect ran while not selected");

  cd_nodrive_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && cdActive && detState_q == srpcd_pkg::DET_SENSE && hostOob && !ch1TermSensed
    |=> cable_present_n)
    else $error("status not raised when no termination found");

  cd_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && cdActive && detState_q == srpcd_pkg::DET_SENSE && !hostOob
    |=> !cable_present_n)
    else $error("status rose without host signalling");

  cd_cominit_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && cdActive && detState_q == srpcd_pkg::DET_LISTEN && ch2Cominit
    |=> !cable_present_n)
    else $error("status not lowered on init burst");

  preemph_sel_a: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn |=> txPreemph == {$past(preemph_sel_ch2), $past(preemph_sel_ch1)})
    else $error("pre-emphasis does not follow its select pins");

endmodule // srpcd_top

//--- srpcd_far_end.sv
// Far side model: SATA host on channel 1, external drive on channel 2.
// Assumes tasks are called by the bench; every change lands on a rising edge.
`timescale 1ns/1ns
module srpcd_far_end (
  // Clock and status pin
  input wire logic ref_clk,
  input wire logic cable_present_n,
  // Detector outputs toward the block
  output logic [1:0] rxActivity,
  output logic hostOob,
  output logic ch1TermSensed,
  output logic ch2Cominit
);
  logic driveAttached;
  initial begin
    rxActivity = 2'h3;
    hostOob = 1'b0;
    ch1TermSensed = 1'b1;
    ch2Cominit = 1'b0;
    driveAttached = 1'b1;
  end
  // ==========================================================================
  // Drive socket: termination is only seen through channel 1
  task automatic plug(input logic on);
    @(posedge ref_clk);
    ch1TermSensed <= on;
    driveAttached = on;
  endtask
  // A shut-down host sends no reset bursts at all
  task automatic host_burst();
    @(posedge ref_clk);
    if (cable_present_n === 1'b0) begin
      hostOob <= 1'b1;
    end
    @(posedge ref_clk);
    hostOob <= 1'b0;
  endtask
  // A detached drive cannot announce itself
  task automatic drive_init();
    @(posedge ref_clk);
    ch2Cominit <= driveAttached;
    @(posedge ref_clk);
    ch2Cominit <= 1'b0;
  endtask
  task automatic activity(input logic [1:0] a);
    @(posedge ref_clk);
    rxActivity <= a;
  endtask
endmodule // srpcd_far_end

//--- tb_srpcd_top.sv
// Self-checking bench for the redriver control block.
// Assumes srpcd_far_end as the far side and short resume and idle counts.
`timescale 1ns/1ns
module tb_srpcd_top;
  // ==========================================================================
  // Signals
  localparam int RES_C = 4;
  localparam int IDL_C = 6;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic enable = 1'b0;
  logic cable_detect_select = 1'b1;
  logic preemph_sel_ch1 = 1'b0;
  logic preemph_sel_ch2 = 1'b0;
  logic [1:0] rxActivity, txDriveEn, auto_low_power, txCommonMode, txPass, txPreemph;
  logic hostOob, ch1TermSensed, ch2Cominit, biasOn, cable_present_n;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  int n_mismatch = 0;
  int n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  srpcd_top #(.RESUME_CYC(RES_C), .IDLE_CYC(IDL_C), .ADDR_W(4)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .enable(enable),
    .cable_detect_select(cable_detect_select), .preemph_sel_ch1(preemph_sel_ch1),
    .preemph_sel_ch2(preemph_sel_ch2), .rxActivity(rxActivity), .hostOob(hostOob),
    .ch1TermSensed(ch1TermSensed), .ch2Cominit(ch2Cominit), .txDriveEn(txDriveEn),
    .auto_low_power(auto_low_power), .txCommonMode(txCommonMode), .txPass(txPass),
    .txPreemph(txPreemph), .biasOn(biasOn), .cable_present_n(cable_present_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  srpcd_far_end i_far (
    .ref_clk(ref_clk), .cable_present_n(cable_present_n), .rxActivity(rxActivity),
    .hostOob(hostOob), .ch1TermSensed(ch1TermSensed), .ch2Cominit(ch2Cominit)
  );
  // ==========================================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk({txDriveEn, biasOn, cable_present_n}, 4'h0);
    axi_rd(srpcd_pkg::CTRL_ADDR);
    chk(rd, 32'h3);
    axi_rd(srpcd_pkg::STATUS_ADDR);
    chk(rd, 32'h2);
    axi_rd(4'h8);
    chk(rd, 32'h0);
    chk(rs, srpcd_pkg::RESP_DECERR);
  endtask
  task automatic t_wake();
    @(posedge ref_clk);
    enable <= 1'b1;
    cyc(1);
    chk({txDriveEn, biasOn}, 3'h7);
    cyc(RES_C);
    axi_rd(srpcd_pkg::STATUS_ADDR);
    chk(rd, 32'h1);
  endtask
  task automatic t_preemph();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {preemph_sel_ch2, preemph_sel_ch1} <= i[1:0];
      cyc(3);
      chk(txPreemph, i[1:0]);
    end
    // A low clock enable must freeze the last selection
    @(posedge ref_clk);
    clkEn <= 1'b0;
    {preemph_sel_ch2, preemph_sel_ch1} <= 2'h0;
    cyc(3);
    chk(txPreemph, 2'h3);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    cyc(1);
    chk(txPreemph, 2'h0);
  endtask
  task automatic t_idle();
    i_far.activity(2'h0);
    cyc(IDL_C - 1);
    chk(auto_low_power, 2'h0);
    cyc(3);
    chk({auto_low_power, txPass, txCommonMode}, 6'h33);
    i_far.activity(2'h1);
    cyc(1);
    chk({auto_low_power, txPass, txCommonMode}, 6'h26);
    i_far.activity(2'h3);
    cyc(2);
    // With low power disallowed, a long idle only squelches
    axi_wr(srpcd_pkg::CTRL_ADDR, 32'h1, 4'hF);
    i_far.activity(2'h0);
    cyc(IDL_C + 2);
    chk({auto_low_power, txCommonMode}, 4'h3);
    i_far.activity(2'h3);
    axi_wr(srpcd_pkg::CTRL_ADDR, 32'h3, 4'hF);
  endtask
  task automatic t_detect();
    i_far.host_burst();
    cyc(1);
    chk(cable_present_n, 1'b0);
    i_far.plug(1'b0);
    cyc(3);
    chk(cable_present_n, 1'b0);
    i_far.host_burst();
    cyc(1);
    chk(cable_present_n, 1'b1);
    axi_rd(srpcd_pkg::STATUS_ADDR);
    chk(rd, 32'h31);
    i_far.plug(1'b1);
    i_far.drive_init();
    cyc(1);
    chk(cable_present_n, 1'b0);
    @(posedge ref_clk);
    cable_detect_select <= 1'b0;
    i_far.plug(1'b0);
    i_far.host_burst();
    cyc(1);
    chk(cable_present_n, 1'b0);
    @(posedge ref_clk);
    cable_detect_select <= 1'b1;
    i_far.host_burst();
    cyc(1);
    chk(cable_present_n, 1'b1);
  endtask
  task automatic t_standby();
    @(posedge ref_clk);
    enable <= 1'b0;
    cyc(1);
    chk({txDriveEn, biasOn, cable_present_n, auto_low_power}, 6'h0);
    axi_rd(srpcd_pkg::STATUS_ADDR);
    chk(rd, 32'h2);
    @(posedge ref_clk);
    enable <= 1'b1;
    cyc(2);
    axi_wr(srpcd_pkg::CTRL_ADDR, 32'h0, 4'h0);
    chk(rs, srpcd_pkg::RESP_OKAY);
    axi_rd(srpcd_pkg::CTRL_ADDR);
    chk(rd, 32'h3);
    axi_wr(srpcd_pkg::CTRL_ADDR, 32'h0, 4'hF);
    chk(rs, srpcd_pkg::RESP_OKAY);
    cyc(2);
    chk({txDriveEn, biasOn}, 3'h0);
    axi_wr(srpcd_pkg::STATUS_ADDR, 32'hFF, 4'hF);
    chk(rs, srpcd_pkg::RESP_OKAY);
    axi_rd(srpcd_pkg::STATUS_ADDR);
    chk(rd, 32'h2);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    cyc(1);
    t_reset();
    t_wake();
    t_preemph();
    t_idle();
    t_detect();
    t_standby();
    end_of_test();
  end
  // The whole run needs well under a thousand cycles
  initial begin
    #(100 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule // tb_srpcd_top
